/* design/smrf_pkg.sv */
package smrf_pkg;
  // ==========================================================
  // bus word and register map
  typedef logic [31:0] smrf_word_t;
  localparam logic [11:0] OFS_EVENT  = 12'h108; // sticky ready event
  localparam logic [11:0] OFS_MASK   = 12'h304; // interrupt mask
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_RX_BYTE = 12'h518;
  localparam logic [11:0] OFS_TX_BYTE = 12'h51c;
  localparam logic [11:0] OFS_FREQ   = 12'h524;
  localparam logic [11:0] OFS_CFG    = 12'h554;
  // ==========================================================
  // reset values and fields
  localparam smrf_word_t RST_FREQ = 32'h04000000;
  localparam smrf_word_t RST_CFG  = 32'h00000000;
  localparam int CFG_ORDER = 0;    // 0 high_bit_leads, 1 low_bit_leads
  localparam int CFG_PHASE    = 1; // clock_phase
  localparam int CFG_POLARITY = 2; // clock_polarity
  localparam int FREQ_LSB  = 25;   // rate_125k one-hot position
  localparam int FREQ_MSB  = 31;   // rate_8m one-hot position
  // ==========================================================
  // timing
  localparam int CLK_HZ       = 20_000_000; // fast_system_clock
  localparam int RATE_125K    = 125_000;    // bits per second
  localparam int HALF_125K    = CLK_HZ / (2 * RATE_125K);
  localparam int START_NS     = 1000;       // write to shifting
  localparam int START_CYC    = START_NS / (1_000_000_000 / CLK_HZ);
  localparam int BITS         = 8;
  localparam int EDGES        = 2 * BITS;
  typedef enum logic {SMRF_IDLE, SMRF_SHIFT} smrf_state_t;
endpackage : smrf_pkg

/* design/smrf_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - a one-hot rate code from 125 kbps at bit 25 doubling per bit to 2 Mbps at bit 29, then 5 and 10 Mbps at bits 30 and 31, sets sck.
// - the half period is a whole number of system clocks, so bits 30 and 31 run faster than their doubled rates.
// - order 0 shifts each byte out high bit first, order 1 low bit first.
// - with phase 0 data in is sampled on the leading edge and data out changes on the trailing.
// - with phase 1 data in is sampled on the trailing edge and data out changes on the leading.
// - polarity 0 idles the clock low, polarity 1 idles it high.
// - a byte written to transmit while idle starts shifting within about one microsecond; one written mid-byte waits for that byte to end.
// - the ready event rises once the byte is sent and the received byte sits in receive.
// - the master only works while its enable bit is 1.
module smrf_master
  import smrf_pkg::*;
(
  input  wire logic               hclk,      // system clock
  input  wire logic               hresetn,   // async reset
  input  wire logic               hsel,      // slave select
  input  wire smrf_pkg::smrf_word_t haddr,   // byte address
  input  wire logic [1:0]         htrans,    // transfer type
  input  wire logic               hwrite,    // write access
  input  wire logic [2:0]         hsize,     // word only
  input  wire smrf_pkg::smrf_word_t hwdata,  // write data
  input  wire logic               hready,    // bus ready
  output logic                    hreadyout, // slave ready
  output logic                    hresp,     // always okay
  output smrf_pkg::smrf_word_t    hrdata,    // read data
  output logic                    sck,       // serial clock
  output logic                    mosi,      // data out
  input  wire logic               miso,      // data in
  output logic                    irq        // level interrupt
);
  import smrf_pkg::*;

  localparam int LAT_MAX = START_CYC;

  // ==========================================================
  // rate decode
  // unknown codes fall back to the slowest rate
  function automatic logic [7:0] half_of(input smrf_word_t f);
    logic [7:0] h;
    h = 8'(HALF_125K);
    for (int i = FREQ_LSB; i <= FREQ_MSB; i++) begin
      if (f == (smrf_word_t'(1) << i)) begin
        h = 8'(HALF_125K >> (i - FREQ_LSB));
      end
    end
    if (h == 8'h00) begin
      h = 8'h01;
    end
    return h;
  endfunction : half_of

  // ==========================================================
  // state
  logic        ph_wr, ph_rd, next_ph_wr, next_ph_rd;
  logic [11:0] ph_addr, next_ph_addr;
  smrf_word_t  next_hrdata;
  logic        en, next_en, mask, next_mask, evt, next_evt;
  logic [7:0]  tx_byte, next_tx_byte, rx_byte, next_rx_byte;
  logic        pend, next_pend;
  smrf_word_t  freq, next_freq;
  logic [2:0]  cfg, next_cfg;
  smrf_state_t st, next_st;
  logic [7:0]  tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [7:0]  div, next_div;
  logic [3:0]  edges, next_edges;
  logic        act, next_act, next_sck, next_mosi, next_irq;
  logic        miso_m, miso_s;
  logic        done;
  logic [7:0]  half;
  logic        busy, wr_tx;

  assign half = half_of(freq);
  assign busy = (st == SMRF_SHIFT);
  assign wr_tx = ph_wr && (ph_addr == OFS_TX_BYTE);

  // ==========================================================
  // bus slave: writes zero wait, reads one wait state
  assign hreadyout = !ph_rd;
  assign hresp     = 1'b0;

  always_comb begin
    next_ph_wr   = 1'b0;
    next_ph_rd   = 1'b0;
    next_ph_addr = ph_addr;
    next_hrdata  = hrdata;
    if (hsel && hready && htrans[1]) begin
      next_ph_wr   = hwrite;
      next_ph_rd   = !hwrite;
      next_ph_addr = {haddr[11:2], 2'b00};
    end
    // read data taken late so a write just before is seen
    if (ph_rd) begin
      if (ph_addr == OFS_EVENT) begin
        next_hrdata = {31'h0, evt};
      end else if (ph_addr == OFS_MASK) begin
        next_hrdata = {31'h0, mask};
      end else if (ph_addr == OFS_ENABLE) begin
        next_hrdata = {31'h0, en};
      end else if (ph_addr == OFS_RX_BYTE) begin
        next_hrdata = {24'h0, rx_byte};
      end else if (ph_addr == OFS_TX_BYTE) begin
        next_hrdata = {24'h0, tx_byte};
      end else if (ph_addr == OFS_FREQ) begin
        next_hrdata = freq;
      end else if (ph_addr == OFS_CFG) begin
        next_hrdata = {29'h0, cfg};
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 12'h000;
      hrdata  <= 32'h00000000;
    end else begin
      ph_wr   <= next_ph_wr;
      ph_rd   <= next_ph_rd;
      ph_addr <= next_ph_addr;
      hrdata  <= next_hrdata;
    end
  end

  // ==========================================================
  // miso synchroniser, only the second stage is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_m <= miso;
      miso_s <= miso_m;
    end
  end

  // ==========================================================
  // registers and shifter
  always_comb begin
    logic lead, smp;
    lead        = 1'b0;
    smp         = 1'b0;
    done        = 1'b0;
    next_en     = en;
    next_mask   = mask;
    next_evt    = evt;
    next_tx_byte = tx_byte;
    next_rx_byte = rx_byte;
    next_pend   = pend;
    next_freq   = freq;
    next_cfg    = cfg;
    next_st     = st;
    next_tx_sh  = tx_sh;
    next_rx_sh  = rx_sh;
    next_div    = div;
    next_edges  = edges;
    next_act    = act;
    next_mosi   = mosi;
    // software writes
    if (ph_wr) begin
      if (ph_addr == OFS_EVENT) begin
        next_evt = evt && !hwdata[0];          // write one clears
      end else if (ph_addr == OFS_MASK) begin
        next_mask = hwdata[0];
      end else if (ph_addr == OFS_ENABLE) begin
        next_en = hwdata[0];
      end else if (ph_addr == OFS_TX_BYTE) begin
        next_tx_byte = hwdata[7:0];
        next_pend = 1'b1;
      end else if (ph_addr == OFS_FREQ) begin
        next_freq = hwdata;
      end else if (ph_addr == OFS_CFG) begin
        next_cfg = hwdata[2:0];
      end
    end
    case (st)
      SMRF_IDLE: begin
        next_act = 1'b0;
        if (en && pend && !wr_tx) begin
          next_st    = SMRF_SHIFT;
          next_pend  = 1'b0;
          next_tx_sh = tx_byte;
          next_div   = 8'h00;
          next_edges = 4'h0;
          // phase 0 puts the first bit out before the leading edge
          if (!cfg[CFG_PHASE]) begin
            next_mosi  = cfg[CFG_ORDER] ? tx_byte[0] : tx_byte[7];
            next_tx_sh = cfg[CFG_ORDER] ? (tx_byte >> 1) : (tx_byte << 1);
          end
        end
      end
      SMRF_SHIFT: begin
        if (!en) begin
          next_st  = SMRF_IDLE;
          next_act = 1'b0;
        end else if (div == half - 8'h01) begin
          next_div = 8'h00;
          next_act = !act;
          lead     = !edges[0];
          smp      = lead ^ cfg[CFG_PHASE];
          if (smp) begin
            next_rx_sh = cfg[CFG_ORDER] ? {miso_s, rx_sh[7:1]}
                                        : {rx_sh[6:0], miso_s};
          end else if (edges != 4'(EDGES - 1)) begin
            next_mosi  = cfg[CFG_ORDER] ? tx_sh[0] : tx_sh[7];
            next_tx_sh = cfg[CFG_ORDER] ? (tx_sh >> 1) : (tx_sh << 1);
          end
          if (edges == 4'(EDGES - 1)) begin
            done     = 1'b1;
            next_st  = SMRF_IDLE;
            next_rx_byte = next_rx_sh;
          end else begin
            next_edges = edges + 4'h1;
          end
        end else begin
          next_div = div + 8'h01;
        end
      end
      default: next_st = SMRF_IDLE;
    endcase
    // a new event beats a clear in the same cycle
    if (done) begin
      next_evt = 1'b1;
    end
    next_sck = next_cfg[CFG_POLARITY] ^ next_act;
    next_irq = next_evt && next_mask;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en    <= 1'b0;
      mask  <= 1'b0;
      evt   <= 1'b0;
      tx_byte <= 8'h00;
      rx_byte <= 8'h00;
      pend  <= 1'b0;
      freq  <= RST_FREQ;
      cfg   <= RST_CFG[2:0];
      st    <= SMRF_IDLE;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      div   <= 8'h00;
      edges <= 4'h0;
      act   <= 1'b0;
      sck   <= RST_CFG[CFG_POLARITY];
      mosi  <= 1'b0;
      irq   <= 1'b0;
    end else begin
      en    <= next_en;
      mask  <= next_mask;
      evt   <= next_evt;
      tx_byte <= next_tx_byte;
      rx_byte <= next_rx_byte;
      pend  <= next_pend;
      freq  <= next_freq;
      cfg   <= next_cfg;
      st    <= next_st;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      div   <= next_div;
      edges <= next_edges;
      act   <= next_act;
      sck   <= next_sck;
      mosi  <= next_mosi;
      irq   <= next_irq;
    end
  end

  // ==========================================================
  // checks
  a_rate_divider: assert property (@(posedge hclk) disable iff (!hresetn)
    (busy && en && $stable(cfg) && div != half - 8'h01) |=> $stable(sck))
    else $error("sck moved before the divider ran out");

  a_start_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_tx && en && !busy && !pend) |-> ##[1:LAT_MAX] busy)
    else $error("transfer did not start in time");

  a_idle_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (!busy && !$past(busy) && $stable(cfg)) |-> sck == cfg[CFG_POLARITY])
    else $error("sck not at idle level");

  a_high_first: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(busy) && !cfg[CFG_ORDER] && !cfg[CFG_PHASE]) |-> mosi == $past(tx_byte[7]))
    else $error("first bit is not the high bit");

  a_low_first: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(busy) && cfg[CFG_ORDER] && !cfg[CFG_PHASE]) |-> mosi == $past(tx_byte[0]))
    else $error("first bit is not the low bit");

  a_lead_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (busy && !cfg[CFG_PHASE] && $changed(rx_sh)) |-> sck != cfg[CFG_POLARITY])
    else $error("phase 0 sampled off the leading edge");

  a_trail_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg[CFG_PHASE] && $stable(cfg) && $changed(rx_sh)) |-> sck == cfg[CFG_POLARITY])
    else $error("phase 1 sampled off the trailing edge");

  a_ready_event: assert property (@(posedge hclk) disable iff (!hresetn)
    done |=> evt && rx_byte == $past(next_rx_sh) && !busy)
    else $error("ready event or received byte missing");

  a_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (!en && !$past(en)) |-> !busy)
    else $error("shifting while disabled");

  a_sixteen_edges: assert property (@(posedge hclk) disable iff (!hresetn)
    done |-> edges == 4'(EDGES - 1) && !next_act)
    else $error("byte ended off sixteen clock edges");

endmodule : smrf_master
`default_nettype wire

/* dv/smrf_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural far-side serial slave, no select line
module smrf_slave (
  input  wire logic       sck,     // serial clock from master
  input  wire logic       mosi,    // data from master
  input  wire logic       clock_polarity,    // idle level of sck
  input  wire logic       clock_phase,    // 0 samples on leading edge
  input  wire logic       lsb,     // 1 low bit travels first
  input  wire logic       frame_start, // rising edge starts a frame
  input  wire logic [7:0] tx_byte, // byte sent back
  output logic            miso,    // data to master
  output logic [7:0]      rx_byte  // byte captured from mosi
);
  int   nout;
  int   nin;
  int   nedge;
  logic live;
  initial miso = 1'b0;
  initial live = 1'b0;
  function automatic int pos(input int k);
    return lsb ? k : 7 - k;
  endfunction : pos
  // phase 0 puts the first bit up before any edge
  always @(posedge frame_start) begin
    nout = 0;
    nin = 0;
    nedge = 0;
    live = 1'b1;
    rx_byte = 8'h00;
    if (!clock_phase) begin
      miso = tx_byte[pos(0)];
      nout = 1;
    end
  end
  // leading edge leaves the idle level; sample or shift per phase
  always @(sck) begin
    if (live) begin
      if ((sck !== clock_polarity) ^ clock_phase) begin
        rx_byte[pos(nin)] = mosi;
        nin++;
      end else if (nout < 8) begin
        miso = tx_byte[pos(nout)];
        nout++;
      end
      nedge++;
      // after the frame the line shows no stale bit
      if (nedge == 16) begin
        live = 1'b0;
        miso = ~miso;
      end
    end
  end
endmodule : smrf_slave
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smrf_pkg::*;
  logic       hclk = 1'b0;
  logic       hresetn = 1'b0;
  logic       hsel = 1'b0;
  logic       hwrite = 1'b0;
  logic       frame_start = 1'b0;
  logic [1:0] htrans = 2'h0;
  smrf_word_t haddr = 32'h0;
  smrf_word_t hwdata = 32'h0;
  smrf_word_t hrdata;
  smrf_word_t rd;
  wire logic  hreadyout;
  wire logic  hresp;
  wire logic  sck;
  wire logic  mosi;
  wire logic  miso;
  wire logic  irq;
  logic [7:0] sb;
  logic [7:0] mb;
  logic [7:0] srx;
  logic [2:0] cfg = 3'h0;
  int         err_count = 0;
  int         cmp_count = 0;
  int         n;
  int         h;
  always #25 hclk = ~hclk;
  smrf_master smrf_master_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sck,
    .mosi, .miso, .irq);
  smrf_slave smrf_slave_inst (.sck, .mosi, .miso, .clock_polarity(cfg[2]), .clock_phase(cfg[1]),
    .lsb(cfg[0]), .frame_start, .tx_byte(sb), .rx_byte(srx));
  // ==========================================================
  // bus tasks: address phase held until hready, then data phase
  task xfer(input logic w, input logic [11:0] a, input smrf_word_t d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task chk(input smrf_word_t g, input smrf_word_t e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task rchk(input logic [11:0] a, input smrf_word_t e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rchk
  // cycles until sck moves; bounded so a dead clock cannot hang
  task wedge();
    logic s;
    s = sck;
    n = 0;
    do begin @(posedge hclk); n++; end while (sck === s && n < 4000);
  endtask : wedge
  task stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // watchdog well past the slowest expected run
  initial begin
    #3000000;
    err_count++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFS_FREQ, RST_FREQ);
    rchk(OFS_CFG, RST_CFG);
    rchk(OFS_EVENT, 32'h0);
    rchk(OFS_MASK, 32'h0);
    rchk(12'h100, 32'h0);
    xfer(1'b1, OFS_ENABLE, 32'h1);
    $display("test reset values done");
    // every mode, order and rate; slow rates also check the echo
    for (int i = 0; i < 8; i++) begin
      cfg <= i[2:0];
      h = 80 >> (i % 7);
      sb <= 8'(32'h3c ^ (32'h11 * i));
      mb = 8'(32'ha5 + i);
      xfer(1'b1, OFS_CFG, {29'h0, i[2:0]});
      xfer(1'b1, OFS_FREQ, 32'h1 << (25 + i % 7));
      xfer(1'b1, OFS_MASK, {31'h0, i != 0});
      rchk(OFS_CFG, {29'h0, i[2:0]});
      chk({31'h0, sck}, {31'h0, cfg[2]});
      frame_start <= 1'b1;
      @(posedge hclk);
      frame_start <= 1'b0;
      xfer(1'b1, OFS_TX_BYTE, {24'h0, mb});
      wedge();
      chk({31'h0, n <= h + START_CYC}, 32'h1);
      wedge();
      chk(smrf_word_t'(n), smrf_word_t'(h));
      rd = 32'h0;
      for (int k = 0; k < 200 && rd[0] !== 1'b1; k++) begin
        repeat (20) @(posedge hclk);
        xfer(1'b0, OFS_EVENT, 32'h0);
      end
      chk({31'h0, rd[0]}, 32'h1);
      chk({31'h0, irq}, {31'h0, i != 0});
      chk({31'h0, sck}, {31'h0, cfg[2]});
      chk({24'h0, srx}, {24'h0, mb});
      if (h >= 5) rchk(OFS_RX_BYTE, {24'h0, sb});
      rchk(OFS_TX_BYTE, {24'h0, mb});
      xfer(1'b1, OFS_EVENT, 32'h1);
      rchk(OFS_EVENT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test byte %0d done", i);
    end
    // receive register ignores writes
    xfer(1'b1, OFS_RX_BYTE, 32'hff);
    rchk(OFS_RX_BYTE, {24'h0, sb});
    // disabled master must not shift, and disabling aborts a byte
    xfer(1'b1, OFS_ENABLE, 32'h0);
    xfer(1'b1, OFS_TX_BYTE, 32'h5a);
    repeat (200) @(posedge hclk);
    chk({31'h0, sck}, {31'h0, cfg[2]});
    rchk(OFS_EVENT, 32'h0);
    xfer(1'b1, OFS_ENABLE, 32'h1);
    xfer(1'b1, OFS_TX_BYTE, 32'h5a);
    repeat (300) @(posedge hclk);
    xfer(1'b1, OFS_ENABLE, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, sck}, {31'h0, cfg[2]});
    repeat (2000) @(posedge hclk);
    rchk(OFS_EVENT, 32'h0);
    $display("test enable done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
